// file: rtl/flag_capture.sv
// Purpose: Bank of sticky flags that capture synchronised source events and clear on read.
// Assumes: Sources are asynchronous to aclk; mode is static logic on aclk.
// Notes:   A set in the clearing cycle survives the clear.
`timescale 1ns/1ps
module flag_capture #(
	parameter int unsigned W = 4
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [W-1:0]       src,
	input  wire logic [2*W-1:0]     mode,
	input  wire logic               clear,
	output logic      [W-1:0]       flags,
	output logic                    new_event
);
	import irq_flags_pkg::*;

	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;
	logic [W-1:0] hit;
	logic [W-1:0] kept;
	logic [W-1:0] next_flags;

	// Decides whether one bit's selected trigger fired this cycle.
	function automatic logic trigger_hit(input logic [1:0] sel, input logic rise, input logic fall,
		input logic level);
		case (sel)
			TRIG_RISE: trigger_hit = rise;
			TRIG_FALL: trigger_hit = fall;
			TRIG_BOTH: trigger_hit = rise | fall;
			TRIG_HIGH: trigger_hit = level;
			default:   trigger_hit = 1'b0;
		endcase
	endfunction

	// Two-stage synchroniser followed by a history stage for edge detection.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta   <= '0;
			stable <= '0;
			prev   <= '0;
		end else begin
			meta   <= src;
			stable <= meta;
			prev   <= stable;
		end
	end

	// Per-bit trigger decode; fixed rising mode gives edge-only capture.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			hit[i] = trigger_hit(mode[2*i +: 2], stable[i] & ~prev[i], ~stable[i] & prev[i], stable[i]);
		end
	end

	// Clear by read, then merge new hits so that a set wins over the clear.
	assign kept       = clear ? '0 : flags;    // R01
	assign next_flags = kept | hit;            // R11
	assign new_event  = |(hit & ~kept);

	// Sticky flag storage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;                        // R10
		end else begin
			flags <= next_flags;                // R02
		end
	end

endmodule

// file: rtl/pmic_irq_status_flags.sv
// Purpose: Second-level interrupt status words for supply, thermal, watchdog, regulator and pin events.
// Assumes: Source conditions come from other clock domains or pins; AXI4-Lite master on aclk.
// Notes:   Status words clear when read; a summary register with mask drives one interrupt line.
//
// Summary of operation
// R01: Reading a status word clears its flags.
// R02: Non-pin flags set on rising edge, stay until read.
// R03: Bit 3 latches supply below shutdown threshold.
// R04: Bit 2 latches die over lower limit.
// R05: Bit 1 latches die over upper limit.
// R06: Bit 0 latches watchdog timeout expiry.
// R07: Linear regulators bits 11-8, switchers bits 5-0.
// R08: Overcurrent word holds limit switch flag, bit 15.
// R09: Pin n flag in bit n, trigger per pin.
// R10: Flags reset to zero; unlisted bits read zero.
// R11: Event during clearing read stays set afterwards.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module pmic_irq_status_flags (
	input  wire logic                               aclk,
	input  wire logic                               aresetn,
	input  wire logic [irq_flags_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [irq_flags_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	output logic [1:0]                              s_axi_bresp,
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [irq_flags_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	output logic [irq_flags_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	input  wire irq_flags_pkg::system_sources_t     system_sources,
	input  wire irq_flags_pkg::undervolt_sources_t  undervolt_sources,
	input  wire logic                               limit_switch_overcurrent,
	input  wire logic [irq_flags_pkg::PIN_COUNT-1:0] pin_level,
	input  wire irq_flags_pkg::pin_triggers_t       pin_trigger,
	output logic                                    irq
);
	import irq_flags_pkg::*;

	// Fixed rising-edge modes for the non-pin banks.
	localparam logic [2*SYS_FLAG_COUNT-1:0] SYS_MODES = {SYS_FLAG_COUNT{TRIG_RISE}};
	localparam logic [2*(LINREG_COUNT+SWITCHER_COUNT)-1:0] UV_MODES = {(LINREG_COUNT+SWITCHER_COUNT){TRIG_RISE}};
	localparam logic [1:0] OC_MODES = TRIG_RISE;

	// Write channel state.
	wr_state_t           wr_state;
	wr_state_t           next_wr_state;
	logic                aw_held;
	logic                w_held;
	logic [5:0]          aw_index;
	logic [DATA_W-1:0]   w_data;
	logic [3:0]          w_strb;

	// Read channel state.
	rd_state_t           rd_state;
	rd_state_t           next_rd_state;
	logic [DATA_W-1:0]   read_data;
	logic [1:0]          read_resp;
	logic [1:0]          write_resp;

	// Flag banks and summary.
	logic [SYS_FLAG_COUNT-1:0]                sys_flags;
	logic [LINREG_COUNT+SWITCHER_COUNT-1:0]   uv_flags;
	logic [0:0]                               oc_flags;
	logic [PIN_COUNT-1:0]                     pin_flags;
	logic [IRQ_W-1:0]                         irq_pending;
	logic [IRQ_W-1:0]                         irq_mask;
	logic [IRQ_W-1:0]                         next_irq_pending;
	logic [IRQ_W-1:0]                         bank_events;
	logic [IRQ_W-1:0]                         pending_w1c;

	// Decoded access strobes.
	wire                 aw_take       = s_axi_awvalid & s_axi_awready;
	wire                 w_take        = s_axi_wvalid & s_axi_wready;
	wire                 ar_take       = s_axi_arvalid & s_axi_arready;
	wire [5:0]           ar_index      = s_axi_araddr[7:2];
	wire                 write_commit  = (wr_state == WR_IDLE) & aw_held & w_held;
	wire                 write_low_en  = write_commit & w_strb[0];
	wire                 write_pending = write_low_en & (aw_index == IRQ_PENDING_IDX);
	wire                 write_mask    = write_low_en & (aw_index == IRQ_MASK_IDX);
	wire                 read_sys      = ar_take & (ar_index == SYS_STATUS_TWO_IDX);
	wire                 read_uv       = ar_take & (ar_index == UNDERVOLT_IDX);
	wire                 read_oc       = ar_take & (ar_index == OVERCURRENT_IDX);
	wire                 read_pin      = ar_take & (ar_index == PIN_EVENT_IDX);

	// Status word images; unlisted positions stay zero.
	wire [15:0]          sys_word;
	wire [15:0]          uv_word;
	wire [15:0]          oc_word;
	wire [15:0]          pin_word;

	// Reports whether a word index is part of the register map.
	function automatic logic index_mapped(input logic [5:0] idx);
		index_mapped = (idx == SYS_STATUS_TWO_IDX) | (idx == UNDERVOLT_IDX) | (idx == OVERCURRENT_IDX) |
			(idx == PIN_EVENT_IDX) | (idx == IRQ_PENDING_IDX) | (idx == IRQ_MASK_IDX);
	endfunction

	// Returns the 32-bit read image of a register index.
	function automatic logic [DATA_W-1:0] read_image(input logic [5:0] idx);
		case (idx)
			SYS_STATUS_TWO_IDX: read_image = {16'h0000, sys_word};
			UNDERVOLT_IDX:      read_image = {16'h0000, uv_word};
			OVERCURRENT_IDX:    read_image = {16'h0000, oc_word};
			PIN_EVENT_IDX:      read_image = {16'h0000, pin_word};
			IRQ_PENDING_IDX:    read_image = {28'h000_0000, irq_pending};
			IRQ_MASK_IDX:       read_image = {28'h000_0000, irq_mask};
			default:            read_image = 32'h0000_0000;
		endcase
	endfunction

	// System word bank: supply, two thermal limits and watchdog, each on its rising edge.
	flag_capture #(
		.W         (SYS_FLAG_COUNT)
	) sys_bank (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.src       (system_sources),    // R03 R04 R05 R06
		.mode      (SYS_MODES),         // R02
		.clear     (read_sys),          // R01
		.flags     (sys_flags),
		.new_event (bank_events[IRQ_SYS_BIT])
	);

	// Regulator under-voltage bank, linear regulators above switchers.
	flag_capture #(
		.W         (LINREG_COUNT + SWITCHER_COUNT)
	) uv_bank (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.src       (undervolt_sources),
		.mode      (UV_MODES),          // R02
		.clear     (read_uv),           // R01
		.flags     (uv_flags),
		.new_event (bank_events[IRQ_UV_BIT])
	);

	// Current limit switch overcurrent bank.
	flag_capture #(
		.W         (1)
	) oc_bank (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.src       (limit_switch_overcurrent),
		.mode      (OC_MODES),          // R02
		.clear     (read_oc),           // R01
		.flags     (oc_flags),
		.new_event (bank_events[IRQ_OC_BIT])
	);

	// Pin bank, each pin with the trigger its configuration selects.
	flag_capture #(
		.W         (PIN_COUNT)
	) pin_bank (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.src       (pin_level),
		.mode      (pin_trigger),       // R09
		.clear     (read_pin),          // R01
		.flags     (pin_flags),
		.new_event (bank_events[IRQ_PIN_BIT])
	);

	// Place each bank's flags at its documented positions.
	assign sys_word = {12'h000, sys_flags};                                   // R03 R04 R05 R06 R10
	assign uv_word  = {4'h0, uv_flags[SWITCHER_COUNT +: LINREG_COUNT], 2'h0,
		uv_flags[SWITCHER_COUNT-1:0]};                                         // R07 R10
	assign oc_word  = {oc_flags, 15'h0000};                                   // R08 R10
	assign pin_word = {3'h0, pin_flags};                                      // R09 R10

	// Handshake outputs follow the channel state.
	assign s_axi_awready = (wr_state == WR_IDLE) & ~aw_held;
	assign s_axi_wready  = (wr_state == WR_IDLE) & ~w_held;
	assign s_axi_bvalid  = (wr_state == WR_RESP);
	assign s_axi_bresp   = write_resp;
	assign s_axi_arready = (rd_state == RD_IDLE);
	assign s_axi_rvalid  = (rd_state == RD_DATA);
	assign s_axi_rdata   = read_data;
	assign s_axi_rresp   = read_resp;

	// Write state transitions: collect both halves, commit, then answer.
	always_comb begin
		next_wr_state = wr_state;
		case (wr_state)
			WR_IDLE: begin
				if (write_commit) begin
					next_wr_state = WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					next_wr_state = WR_IDLE;
				end
			end
			default: next_wr_state = WR_IDLE;
		endcase
	end

	// Read state transitions: one read in flight until the master takes the data.
	always_comb begin
		next_rd_state = rd_state;
		case (rd_state)
			RD_IDLE: begin
				if (ar_take) begin
					next_rd_state = RD_DATA;
				end
			end
			RD_DATA: begin
				if (s_axi_rready) begin
					next_rd_state = RD_IDLE;
				end
			end
			default: next_rd_state = RD_IDLE;
		endcase
	end

	// Write address and data holding; either may arrive first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			aw_index <= 6'h00;
			w_data   <= 32'h0000_0000;
			w_strb   <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held  <= 1'b1;
				aw_index <= s_axi_awaddr[7:2];
			end else if (write_commit) begin
				aw_held  <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (write_commit) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response and channel state; status words accept and ignore writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state   <= WR_IDLE;
			write_resp <= RESP_OKAY;
		end else begin
			wr_state <= next_wr_state;
			if (write_commit) begin
				write_resp <= index_mapped(aw_index) ? RESP_OKAY : RESP_DECERR;
			end
		end
	end

	// Read data capture at the address handshake; the same edge clears the read word.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state  <= RD_IDLE;
			read_data <= 32'h0000_0000;
			read_resp <= RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			if (ar_take) begin
				read_data <= read_image(ar_index);                          // R01
				read_resp <= index_mapped(ar_index) ? RESP_OKAY : RESP_DECERR;
			end
		end
	end

	// Pending summary: new bank events set, written ones clear, set wins.
	assign pending_w1c      = write_pending ? w_data[IRQ_W-1:0] : 4'h0;
	assign next_irq_pending = (irq_pending & ~pending_w1c) | bank_events;

	// Summary and mask storage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pending <= IRQ_PENDING_RESET;
			irq_mask    <= IRQ_MASK_RESET;
		end else begin
			irq_pending <= next_irq_pending;
			if (write_mask) begin
				irq_mask <= w_data[IRQ_W-1:0];
			end
		end
	end

	// Level interrupt while any unmasked summary bit is pending.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_pending & ~irq_mask);
		end
	end

endmodule

// file: shared/irq_flags_pkg.sv
// Purpose: Shared constants, types and register map for the second-level interrupt flag block.
// Assumes: One 200 MHz clock, AXI4-Lite register access with 32-bit data.
// Notes:   Register indices are word indices; the byte address is four times the index.
package irq_flags_pkg;

	// Bus geometry.
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register word indices.
	localparam logic [5:0] SYS_STATUS_TWO_IDX  = 6'h1a;
	localparam logic [5:0] UNDERVOLT_IDX       = 6'h1c;
	localparam logic [5:0] OVERCURRENT_IDX     = 6'h1d;
	localparam logic [5:0] PIN_EVENT_IDX       = 6'h1e;
	localparam logic [5:0] IRQ_PENDING_IDX     = 6'h30;
	localparam logic [5:0] IRQ_MASK_IDX        = 6'h31;

	// Field positions inside the status words.
	localparam int unsigned SUPPLY_SHUTDOWN_BIT = 3;
	localparam int unsigned DIE_TEMP_LOW_BIT    = 2;
	localparam int unsigned DIE_TEMP_HIGH_BIT   = 1;
	localparam int unsigned WATCHDOG_BIT        = 0;
	localparam int unsigned SYS_FLAG_COUNT      = 4;
	localparam int unsigned LINREG_LSB          = 8;
	localparam int unsigned LINREG_COUNT        = 4;
	localparam int unsigned SWITCHER_LSB        = 0;
	localparam int unsigned SWITCHER_COUNT      = 6;
	localparam int unsigned OVERCURRENT_BIT     = 15;
	localparam int unsigned PIN_COUNT           = 13;

	// Pending-event register layout, one bit per status word.
	localparam int unsigned IRQ_W               = 4;
	localparam int unsigned IRQ_SYS_BIT         = 0;
	localparam int unsigned IRQ_UV_BIT          = 1;
	localparam int unsigned IRQ_OC_BIT          = 2;
	localparam int unsigned IRQ_PIN_BIT         = 3;

	// Values after reset.
	localparam logic [15:0] STATUS_RESET        = 16'h0000;
	localparam logic [3:0]  IRQ_PENDING_RESET   = 4'h0;
	localparam logic [3:0]  IRQ_MASK_RESET      = 4'h0;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Trigger selection for a captured flag.
	typedef enum logic [1:0] {
		TRIG_RISE = 2'h0,
		TRIG_FALL = 2'h1,
		TRIG_BOTH = 2'h2,
		TRIG_HIGH = 2'h3
	} trigger_t;

	typedef trigger_t [PIN_COUNT-1:0] pin_triggers_t;

	// System source conditions, ordered as their bits 3 down to 0.
	typedef struct packed {
		logic supply_below_shutdown;
		logic die_over_low_limit;
		logic die_over_high_limit;
		logic watchdog_expired;
	} system_sources_t;

	// Regulator under-voltage conditions.
	typedef struct packed {
		logic [3:0] linreg;
		logic [5:0] switcher;
	} undervolt_sources_t;

	// Channel state machines.
	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} rd_state_t;

endpackage

// file: test/axi_host_model.sv
// Purpose: Host processor model that reads and writes the flag block over AXI4-Lite.
// Assumes: Requests change right after a rising edge and wait for the answer.
// Notes:   Released address and data lines are inverted so stale values cannot pass.
`timescale 1ns/1ps
module axi_host_model (
	input  wire logic                              aclk,
	output logic [irq_flags_pkg::ADDR_W-1:0]       s_axi_awaddr,
	output logic                                   s_axi_awvalid,
	input  wire logic                              s_axi_awready,
	output logic [irq_flags_pkg::DATA_W-1:0]       s_axi_wdata,
	output logic [3:0]                             s_axi_wstrb,
	output logic                                   s_axi_wvalid,
	input  wire logic                              s_axi_wready,
	input  wire logic [1:0]                        s_axi_bresp,
	input  wire logic                              s_axi_bvalid,
	output logic                                   s_axi_bready,
	output logic [irq_flags_pkg::ADDR_W-1:0]       s_axi_araddr,
	output logic                                   s_axi_arvalid,
	input  wire logic                              s_axi_arready,
	input  wire logic [irq_flags_pkg::DATA_W-1:0]  s_axi_rdata,
	input  wire logic [1:0]                        s_axi_rresp,
	input  wire logic                              s_axi_rvalid,
	output logic                                   s_axi_rready
);
	// All requests idle at time zero.
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// One write: address and data offered together, each released when taken.
	task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_awready) s_axi_awaddr <= ~s_axi_awaddr;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_wready) s_axi_wdata <= ~s_axi_wdata;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// One read: the answer is taken at the edge where rvalid is seen.
	task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_arready) s_axi_araddr <= ~s_axi_araddr;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// file: test/irq_flags_monitor.sv
// Purpose: Concurrent checks on the read port, the write answer and pin capture of the flag block.
// Assumes: One aclk domain with synchronous active-low aresetn.
// Notes:   The word index of the read in flight is tracked locally.
`timescale 1ns/1ps
module irq_flags_monitor (
	input wire logic                                aclk,
	input wire logic                                aresetn,
	input wire logic [irq_flags_pkg::ADDR_W-1:0]    s_axi_araddr,
	input wire logic                                s_axi_arvalid,
	input wire logic                                s_axi_arready,
	input wire logic [irq_flags_pkg::DATA_W-1:0]    s_axi_rdata,
	input wire logic [1:0]                          s_axi_rresp,
	input wire logic                                s_axi_rvalid,
	input wire logic                                s_axi_rready,
	input wire logic                                s_axi_awvalid,
	input wire logic                                s_axi_awready,
	input wire logic                                s_axi_wvalid,
	input wire logic                                s_axi_wready,
	input wire logic                                s_axi_bvalid,
	input wire logic [irq_flags_pkg::PIN_COUNT-1:0] pin_level,
	input wire irq_flags_pkg::pin_triggers_t        pin_trigger
);
	import irq_flags_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [5:0] rd_idx;
	logic [5:0] pin0_hist;
	wire        ar_take = s_axi_arvalid && s_axi_arready;
	// Remembers the read index and how long pin 0 has been high under level trigger.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_idx <= '0;
			pin0_hist <= '0;
		end else begin
			if (ar_take) rd_idx <= s_axi_araddr[7:2];
			pin0_hist <= {pin0_hist[4:0], pin_level[0] && (pin_trigger[0] == TRIG_HIGH)};
		end
	end
	property p_read_answer; ar_take |=> s_axi_rvalid; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");
	property p_read_done; s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid; endproperty
	a_read_done: assert property (p_read_done) else $error("read port not freed after answer");
	property p_write_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not answered");
	property p_sys_unused; s_axi_rvalid && rd_idx == SYS_STATUS_TWO_IDX |-> s_axi_rdata[31:4] == '0; endproperty
	a_sys_unused: assert property (p_sys_unused) else $error("system word unused bits set");
	property p_uv_unused; s_axi_rvalid && rd_idx == UNDERVOLT_IDX |-> !(|s_axi_rdata[31:12]) && !(|s_axi_rdata[7:6]); endproperty
	a_uv_unused: assert property (p_uv_unused) else $error("undervolt word unused bits set");
	property p_oc_unused; s_axi_rvalid && rd_idx == OVERCURRENT_IDX |-> !(|s_axi_rdata[31:16]) && !(|s_axi_rdata[14:0]); endproperty
	a_oc_unused: assert property (p_oc_unused) else $error("overcurrent word unused bits set");
	property p_pin_unused; s_axi_rvalid && rd_idx == PIN_EVENT_IDX |-> s_axi_rdata[31:13] == '0; endproperty
	a_pin_unused: assert property (p_pin_unused) else $error("pin word unused bits set");
	property p_decerr_zero; s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == '0; endproperty
	a_decerr_zero: assert property (p_decerr_zero) else $error("refused read carries data");
	property p_pin_level; ar_take && s_axi_araddr[7:2] == PIN_EVENT_IDX && pin0_hist == 6'h3f |=> s_axi_rdata[0]; endproperty
	a_pin_level: assert property (p_pin_level) else $error("level pin flag missing");
endmodule
bind pmic_irq_status_flags irq_flags_monitor mon_u (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .pin_level, .pin_trigger);

// file: test/pmic_irq_status_flags_test.sv
// Purpose: Self-checking bench for the flag block against a flag model.
// Assumes: 200 MHz aclk, host model on the register bus, sources driven here.
// Notes:   Source vector holds system, undervolt, overcurrent and pin bits in that order.
`timescale 1ns/1ps
module pmic_irq_status_flags_test;
	import irq_flags_pkg::*;
	localparam logic [7:0] PEND_A = {IRQ_PENDING_IDX, 2'b00};
	localparam logic [7:0] MASK_A = {IRQ_MASK_IDX, 2'b00};
	logic              aclk, aresetn, irq;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]        s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, rd_a, rd_b;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
	logic [27:0]       src_vec;
	pin_triggers_t     trig;
	logic [7:0]        wadr [4];
	int                exp_w [4];
	int                mode [13];
	int                errors, total_checks, cycles;
	pmic_irq_status_flags dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.system_sources(system_sources_t'(src_vec[3:0])), .undervolt_sources(undervolt_sources_t'(src_vec[13:4])),
		.limit_switch_overcurrent(src_vec[14]), .pin_level(src_vec[27:15]), .pin_trigger(trig), .irq);
	axi_host_model host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// Clock at 5 ns period.
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Cuts a hang short; the full run needs far fewer cycles than this.
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end
	// Word and bit of each source in the status words.
	function automatic int wi(int i); return i < 4 ? 0 : i < 14 ? 1 : i == 14 ? 2 : 3; endfunction
	function automatic int bi(int i); return i < 4 ? i : i < 10 ? i - 4 : i < 14 ? i - 2 : i == 14 ? 15 : i - 15; endfunction
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Reads a word, compares with the model, then applies the clear.
	task automatic rd_chk(input int w);
		logic [31:0] d;
		logic [1:0]  r;
		int          lvl;
		host_u.read_reg(wadr[w], d, r);
		chk("status word", d, exp_w[w]);
		chk("status resp", r, RESP_OKAY);
		lvl = 0;
		for (int p = 0; p < 13; p++) if (mode[p] == 3 && src_vec[15 + p]) lvl |= 1 << p;
		exp_w[w] = (w == 3) ? lvl : 0;
	endtask
	// Drives new source levels and records which flags they set.
	task automatic set_src(input logic [27:0] v);
		bit hit;
		for (int i = 0; i < 28; i++) begin
			hit = v[i] && !src_vec[i];
			if (i >= 15 && mode[i - 15] == 1) hit = !v[i] && src_vec[i];
			if (i >= 15 && mode[i - 15] == 2) hit = v[i] != src_vec[i];
			if (i >= 15 && mode[i - 15] == 3) hit = v[i];
			if (hit) exp_w[wi(i)] |= 1 << bi(i);
		end
		src_vec <= v;
		repeat (8) @(posedge aclk);
	endtask
	initial begin
		{errors, total_checks, cycles} = '0;
		aresetn = 1'b0;
		src_vec = '0;
		trig = '0;
		exp_w = '{0, 0, 0, 0};
		foreach (mode[i]) mode[i] = 0;
		wadr = '{{SYS_STATUS_TWO_IDX, 2'b00}, {UNDERVOLT_IDX, 2'b00}, {OVERCURRENT_IDX, 2'b00}, {PIN_EVENT_IDX, 2'b00}};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(74));
		for (int w = 0; w < 4; w++) rd_chk(w);
		host_u.read_reg(8'h10, rd_a, resp);
		chk("unmapped resp", resp, RESP_DECERR);
		chk("unmapped data", rd_a, 32'h0000_0000);
		$display("test reset_values done");
		for (int i = 0; i < 28; i++) begin
			set_src(28'h000_0001 << i);
			for (int w = 0; w < 4; w++) rd_chk(w);
			rd_chk(wi(i));
			set_src('0);
			rd_chk(wi(i));
		end
		$display("test bit_map done");
		repeat (6) begin
			set_src(28'($urandom));
			for (int w = 0; w < 4; w++) rd_chk(w);
		end
		$display("test random_sources done");
		set_src('0);
		for (int p = 0; p < 4; p++) begin
			mode[p] = 3 - p;
			trig[p] <= trigger_t'(3 - p);
		end
		set_src(28'h007_8000);
		rd_chk(3);
		rd_chk(3);
		set_src('0);
		rd_chk(3);
		foreach (mode[i]) mode[i] = 0;
		trig <= '0;
		$display("test pin_modes done");
		for (int d = 0; d < 8; d++) begin
			src_vec <= 28'h000_0001;
			repeat (d) @(posedge aclk);
			host_u.read_reg(wadr[0], rd_a, resp);
			host_u.read_reg(wadr[0], rd_b, resp);
			chk("single report", rd_a[0] ^ rd_b[0], 32'h0000_0001);
			src_vec <= '0;
			repeat (6) @(posedge aclk);
		end
		$display("test clear_collision done");
		host_u.write_reg(PEND_A, 32'h0000_000f, resp);
		host_u.write_reg(MASK_A, 32'h0000_0000, resp);
		repeat (2) @(posedge aclk);
		chk("irq idle", irq, 1'b0);
		set_src(28'h000_4000);
		chk("irq raised", irq, 1'b1);
		host_u.read_reg(PEND_A, rd_a, resp);
		chk("pending", rd_a, 32'h0000_0004);
		host_u.write_reg(MASK_A, 32'h0000_0004, resp);
		repeat (2) @(posedge aclk);
		chk("irq masked", irq, 1'b0);
		host_u.write_reg(PEND_A, 32'h0000_0004, resp);
		host_u.write_reg(MASK_A, 32'h0000_0000, resp);
		repeat (2) @(posedge aclk);
		chk("irq cleared", irq, 1'b0);
		host_u.write_reg(wadr[2], 32'hffff_ffff, resp);
		chk("status write resp", resp, RESP_OKAY);
		rd_chk(2);
		host_u.write_reg(8'h10, 32'h0000_0000, resp);
		chk("unmapped write", resp, RESP_DECERR);
		$display("test interrupt done");
		final_report();
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
endmodule
